// File: logic/decrement_and_bcd_adjust_exec.sv
// Execution datapath for BCD adjust, decrement and decrement-skip-if-zero
// Summary of operation
// - BCD adjust: decode, read, process, write accumulator
// - Add six per nibble above nine; carry only
// - Decrement byte; destination bit picks accumulator/file
// - Decrement updates carry, half carry, N, OV, Z
// - Opcode top bits 000001, dest, bank, address
// - Bank bit zero access bank, one bank pointer
// - Extended set, bank zero, f<=95: indexed offset
// - One word, one cycle of four phases
// - Skip variant takes any address, dest, bank
// - Skip variant discards next on zero result
`timescale 1ns/1ps
`include "dec_bcd_regs.svh"

module decrement_and_bcd_adjust_exec (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic next_two_word_i,
   input wire logic [11:0] index_base_i,
   output logic instr_ready_o,
   output logic flush_o,
   output logic [11:0] mem_addr_o,
   output logic mem_rd_o,
   input wire logic [7:0] mem_rdata_i,
   output logic mem_wr_o,
   output logic [7:0] mem_wdata_o,
   output logic [7:0] acc_o,
   output logic [4:0] status_o
);

   dec_bcd_pkg::exec_s s;
   dec_bcd_pkg::exec_s next_s;

   // Operand address: indexed offset, bank pointer or access bank
   function automatic logic [11:0] resolve_addr(input logic [7:0] f,
         input logic banked, input logic ext, input logic [3:0] bank,
         input logic [11:0] base);
      logic [11:0] a;
      a = {`DBX_ACCESS_LO, f};
      if (banked) begin
         a = {bank, f};
      end else if (ext && f <= `DBX_ILO_MAX) begin
         a = base + {4'h0, f};
      end else if (f >= `DBX_ACCESS_SPLIT) begin
         a = {`DBX_ACCESS_HI, f};
      end
      return a;
   endfunction

   // Packed-BCD correction; bit 8 is the carry out
   function automatic logic [8:0] bcd_adjust(input logic [7:0] v,
         input logic c, input logic hc);
      logic [8:0] t;
      t = {1'b0, v};
      if (v[3:0] > `DBX_BCD_LIMIT || hc) begin
         t = t + `DBX_BCD_STEP;
      end
      if (t[8:4] > {1'b0, `DBX_BCD_LIMIT} || c) begin
         t = t + `DBX_BCD_STEP_HI;
      end
      return t;
   endfunction

   always_comb begin
      logic [8:0] adj;
      logic [7:0] dec;
      adj = bcd_adjust(s.operand, s.flags[`DBX_FLAG_C],
                       s.flags[`DBX_FLAG_HC]);
      dec = s.operand - 8'h01;
      next_s = s;

      // Wishbone slave, one wait cycle, unmapped reads zero
      next_s.wb_ack = wb_cyc_i && wb_stb_i && !s.wb_ack;
      next_s.wb_dat = 32'h0000_0000;
      if (next_s.wb_ack && !wb_we_i) begin
         case (wb_adr_i)
            `DBX_OFS_ACC: next_s.wb_dat = {24'h0, s.acc};
            `DBX_OFS_STATUS: next_s.wb_dat = {27'h0, s.flags};
            `DBX_OFS_BANK: next_s.wb_dat = {28'h0, s.bank};
            `DBX_OFS_CTRL: next_s.wb_dat = {31'h0, s.ext_en};
            `DBX_OFS_STATE: next_s.wb_dat = {27'h0, s.phase};
            default: next_s.wb_dat = 32'h0000_0000;
         endcase
      end
      if (next_s.wb_ack && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            `DBX_OFS_ACC: next_s.acc = wb_dat_i[7:0];
            `DBX_OFS_STATUS: next_s.flags = wb_dat_i[4:0];
            `DBX_OFS_BANK: next_s.bank = wb_dat_i[3:0];
            `DBX_OFS_CTRL: next_s.ext_en = wb_dat_i[`DBX_CTRL_EXT];
            default: next_s.acc = s.acc;
         endcase
      end

      // Core updates come after bus writes so they win a collision
      case (s.phase)
         dec_bcd_pkg::ST_DECODE: begin
            if (instr_valid_i) begin
               if (instr_i == `DBX_OPC_ADJUST) begin
                  next_s.op = dec_bcd_pkg::OP_ADJUST;
               end else if (instr_i[15:10] == `DBX_OPC_DEC) begin
                  next_s.op = dec_bcd_pkg::OP_DEC;
               end else if (instr_i[15:10] == `DBX_OPC_DECSKIP) begin
                  next_s.op = dec_bcd_pkg::OP_DECSKIP;
               end else begin
                  next_s.op = dec_bcd_pkg::OP_NONE;
               end
               next_s.dest = instr_i[`DBX_BIT_DEST];
               next_s.addr = resolve_addr(instr_i[7:0],
                  instr_i[`DBX_BIT_BANKSEL], s.ext_en, s.bank,
                  index_base_i);
               next_s.two_word = next_two_word_i;
               next_s.phase = dec_bcd_pkg::ST_READ;
            end
         end
         dec_bcd_pkg::ST_READ: begin
            next_s.operand = (s.op == dec_bcd_pkg::OP_ADJUST) ?
                             s.acc : mem_rdata_i;
            next_s.phase = dec_bcd_pkg::ST_PROCESS;
         end
         dec_bcd_pkg::ST_PROCESS: begin
            next_s.res_flags = s.flags;
            if (s.op == dec_bcd_pkg::OP_ADJUST) begin
               next_s.result = adj[7:0];
               next_s.res_flags[`DBX_FLAG_C] = adj[8] ||
                                               s.flags[`DBX_FLAG_C];
            end else begin
               next_s.result = dec;
               next_s.res_flags[`DBX_FLAG_C] = s.operand != 8'h00;
               next_s.res_flags[`DBX_FLAG_HC] = s.operand[3:0] != 4'h0;
               next_s.res_flags[`DBX_FLAG_Z] = dec == 8'h00;
               next_s.res_flags[`DBX_FLAG_N] = dec[7];
               next_s.res_flags[`DBX_FLAG_OV] = s.operand == `DBX_SIGN_MIN;
            end
            next_s.phase = dec_bcd_pkg::ST_WRITE;
         end
         dec_bcd_pkg::ST_WRITE: begin
            next_s.phase = dec_bcd_pkg::ST_DECODE;
            if (s.op == dec_bcd_pkg::OP_ADJUST ||
                  (s.op != dec_bcd_pkg::OP_NONE && !s.dest)) begin
               next_s.acc = s.result;
            end
            if (s.op == dec_bcd_pkg::OP_DEC ||
                  s.op == dec_bcd_pkg::OP_ADJUST) begin
               next_s.flags = s.res_flags;
            end
            if (s.op == dec_bcd_pkg::OP_DECSKIP && s.result == 8'h00) begin
               next_s.phase = dec_bcd_pkg::ST_SKIP;
               next_s.quarter = 2'h0;
               next_s.skip_left = s.two_word ? 2'h2 : 2'h1;
            end
         end
         dec_bcd_pkg::ST_SKIP: begin
            // One or two idle instruction cycles
            next_s.quarter = s.quarter + 2'h1;
            if (s.quarter == `DBX_QUARTER_LAST) begin
               next_s.skip_left = s.skip_left - 2'h1;
               if (s.skip_left == 2'h1) begin
                  next_s.phase = dec_bcd_pkg::ST_DECODE;
               end
            end
         end
         default: next_s.phase = dec_bcd_pkg::ST_DECODE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.phase <= dec_bcd_pkg::ST_DECODE;
         s.op <= dec_bcd_pkg::OP_NONE;
         s.acc <= `DBX_RST_ACC;
         s.flags <= `DBX_RST_FLAGS;
         s.bank <= `DBX_RST_BANK;
         s.ext_en <= `DBX_RST_EXT;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o = s.wb_ack;
   assign wb_dat_o = s.wb_dat;
   assign instr_ready_o = s.phase == dec_bcd_pkg::ST_DECODE;
   assign flush_o = s.phase == dec_bcd_pkg::ST_SKIP;
   assign mem_addr_o = s.addr;
   // File read in the second quarter
   assign mem_rd_o = s.phase == dec_bcd_pkg::ST_READ &&
                     s.op != dec_bcd_pkg::OP_ADJUST &&
                     s.op != dec_bcd_pkg::OP_NONE;
   assign mem_wr_o = s.phase == dec_bcd_pkg::ST_WRITE && s.dest &&
                     (s.op == dec_bcd_pkg::OP_DEC ||
                      s.op == dec_bcd_pkg::OP_DECSKIP);
   assign mem_wdata_o = s.result;
   assign acc_o = s.acc;
   assign status_o = s.flags;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_accept;
      instr_ready_o && instr_valid_i;
   endsequence

   sequence s_quarters;
      s.phase == dec_bcd_pkg::ST_READ ##1
      s.phase == dec_bcd_pkg::ST_PROCESS ##1
      s.phase == dec_bcd_pkg::ST_WRITE ##1 (instr_ready_o || flush_o);
   endsequence

   chk_phase_order: assert property (s_accept |=> s_quarters)
      else $error("quarter phase order broken");

   chk_adjust_flags: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op == dec_bcd_pkg::OP_ADJUST)
      |=> status_o[4:1] == $past(status_o[4:1]) &&
          (acc_o[3:0] <= `DBX_BCD_LIMIT || $past(s.flags[1])))
      else $error("adjust changed flags beyond carry");

   chk_dec_to_acc: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op == dec_bcd_pkg::OP_DEC &&
       !s.dest) |=> acc_o == $past(s.operand) - 8'h01 && !$past(mem_wr_o))
      else $error("decrement to accumulator wrong");

   chk_dec_to_file: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op != dec_bcd_pkg::OP_ADJUST &&
       s.op != dec_bcd_pkg::OP_NONE && s.dest)
      |-> mem_wr_o && mem_wdata_o == s.operand - 8'h01)
      else $error("decrement to file wrong");

   chk_dec_flags: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op == dec_bcd_pkg::OP_DEC)
      |=> status_o[`DBX_FLAG_Z] == ($past(s.operand) == 8'h01) &&
          status_o[`DBX_FLAG_C] == ($past(s.operand) != 8'h00) &&
          (status_o[`DBX_FLAG_N] == acc_o[7] || $past(s.dest)))
      else $error("decrement flags wrong");

   chk_opcode_dec: assert property (
      (s_accept and instr_i[15:10] == `DBX_OPC_DEC)
      |=> s.op == dec_bcd_pkg::OP_DEC)
      else $error("decrement opcode missed");

   chk_bank_addr: assert property (
      (s_accept and instr_i[`DBX_BIT_BANKSEL])
      |=> mem_addr_o == {$past(s.bank), $past(instr_i[7:0])})
      else $error("bank pointer address wrong");

   chk_indexed: assert property (
      (s_accept and (s.ext_en && !instr_i[`DBX_BIT_BANKSEL] &&
                     instr_i[7:0] <= `DBX_ILO_MAX))
      |=> mem_addr_o == $past(index_base_i) + {4'h0, $past(instr_i[7:0])})
      else $error("indexed offset address wrong");

   chk_no_skip: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op == dec_bcd_pkg::OP_DECSKIP &&
       s.result != 8'h00) |=> instr_ready_o)
      else $error("skip without zero result");

   chk_skip_one: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op == dec_bcd_pkg::OP_DECSKIP &&
       s.result == 8'h00 && !s.two_word) |=> flush_o [*4] ##1 instr_ready_o)
      else $error("single skip length wrong");

   chk_skip_two: assert property (
      (s.phase == dec_bcd_pkg::ST_WRITE && s.op == dec_bcd_pkg::OP_DECSKIP &&
       s.result == 8'h00 && s.two_word) |=> flush_o [*8] ##1 instr_ready_o)
      else $error("double skip length wrong");

endmodule

// File: logic/dec_bcd_regs.svh
// Register offsets, field positions and constants of the decrement/BCD datapath
`ifndef DEC_BCD_REGS_SVH
`define DEC_BCD_REGS_SVH

`define DBX_OFS_ACC 8'h00
`define DBX_OFS_STATUS 8'h04
`define DBX_OFS_BANK 8'h08
`define DBX_OFS_CTRL 8'h0C
`define DBX_OFS_STATE 8'h10

`define DBX_RST_ACC 8'h00
`define DBX_RST_FLAGS 5'h00
`define DBX_RST_BANK 4'h0
`define DBX_RST_EXT 1'b0

`define DBX_FLAG_C 0
`define DBX_FLAG_HC 1
`define DBX_FLAG_Z 2
`define DBX_FLAG_OV 3
`define DBX_FLAG_N 4
`define DBX_CTRL_EXT 0

`define DBX_OPC_ADJUST 16'h0007
`define DBX_OPC_DEC 6'h01
`define DBX_OPC_DECSKIP 6'h0B
`define DBX_BIT_DEST 9
`define DBX_BIT_BANKSEL 8

`define DBX_BCD_LIMIT 4'h9
`define DBX_BCD_STEP 9'h006
`define DBX_BCD_STEP_HI 9'h060
`define DBX_ILO_MAX 8'h5F
`define DBX_ACCESS_SPLIT 8'h60
`define DBX_ACCESS_LO 4'h0
`define DBX_ACCESS_HI 4'hF
`define DBX_SIGN_MIN 8'h80
`define DBX_QUARTER_LAST 2'h3

`endif

// File: logic/dec_bcd_pkg.sv
// Types shared by the decrement/BCD datapath
package dec_bcd_pkg;

   typedef enum logic [4:0] {
      ST_DECODE  = 5'b00001,
      ST_READ    = 5'b00010,
      ST_PROCESS = 5'b00100,
      ST_WRITE   = 5'b01000,
      ST_SKIP    = 5'b10000
   } phase_e;

   typedef enum logic [1:0] {
      OP_NONE    = 2'h0,
      OP_ADJUST  = 2'h1,
      OP_DEC     = 2'h2,
      OP_DECSKIP = 2'h3
   } op_e;

   typedef struct packed {
      phase_e phase;
      op_e op;
      logic dest;
      logic [11:0] addr;
      logic [7:0] operand;
      logic [7:0] result;
      logic [4:0] res_flags;
      logic [7:0] acc;
      logic [4:0] flags;
      logic [3:0] bank;
      logic ext_en;
      logic two_word;
      logic [1:0] quarter;
      logic [1:0] skip_left;
      logic wb_ack;
      logic [31:0] wb_dat;
   } exec_s;

endpackage

// File: testbench/dmem_model.sv
// Behavioural data memory on the far side of the datapath
`timescale 1ns/1ps
module dmem_model (
   input wire logic clk_i,
   input wire logic [11:0] mem_addr_i,
   input wire logic mem_rd_i,
   input wire logic mem_wr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   logic [7:0] mem [0:4095];
   logic [7:0] junk = 8'hA5;
   // Outside a read the bus shows a changing pattern, never stale data
   assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : junk;
   always @(posedge clk_i) begin
      junk <= ~junk;
      if (mem_wr_i) begin
         mem[mem_addr_i] <= mem_wdata_i;
      end
   end
endmodule

// File: testbench/decrement_and_bcd_adjust_exec_tb.sv
// Self-checking bench for the decrement and BCD adjust datapath
`timescale 1ns/1ps
module decrement_and_bcd_adjust_exec_tb;
   logic clk_i = 0;
   logic rst_i = 1;
   logic cyc = 0;
   logic we = 0;
   logic [7:0] adr = 0;
   logic [31:0] wdat = 0;
   logic iv = 0;
   logic tw = 0;
   logic [15:0] instr = 0;
   logic [11:0] base = 0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, instr_ready_o, flush_o, mem_rd_o, mem_wr_o;
   logic [11:0] mem_addr_o;
   logic [7:0] mem_rdata_i, mem_wdata_o, acc_o;
   logic [4:0] status_o;
   int n_errors = 0;
   int n_compared = 0;
   int k;

   always #4 clk_i = ~clk_i;

   decrement_and_bcd_adjust_exec decrement_and_bcd_adjust_exec_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid_i(iv),
      .instr_i(instr), .next_two_word_i(tw), .index_base_i(base),
      .instr_ready_o(instr_ready_o), .flush_o(flush_o),
      .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o),
      .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .status_o(status_o));

   dmem_model dmem_model_inst (
      .clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
      .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o),
      .mem_rdata_o(mem_rdata_i));

   task automatic complete_run;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t got %h expected %h", $time, g, e);
      end
   endtask

   // Bounded wait at the falling edge for ready, counting flush cycles
   task automatic wait_ready(input int lim, output int nf);
      int i;
      nf = 0;
      i = 0;
      do begin
         @(negedge clk_i);
         i++;
         if (flush_o === 1'b1) nf++;
      end while (instr_ready_o !== 1'b1 && i < lim);
      if (instr_ready_o !== 1'b1) begin
         n_errors++;
         complete_run();
      end
   endtask

   // Classic cycle: hold the request until ack is seen at a rising edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int i;
      q = 32'h0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 20);
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         complete_run();
      end
      q = wb_dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic run(input logic [15:0] op, input logic t, output int nf);
      instr <= op;
      tw <= t;
      iv <= 1'b1;
      wait_ready(40, nf);
      @(posedge clk_i);
      iv <= 1'b0;
      wait_ready(40, nf);
      @(posedge clk_i);
   endtask

   task automatic adj(input logic [7:0] a, input logic [4:0] f,
                      input logic [7:0] ea, input logic [4:0] ef);
      int nf;
      wr(8'h00, {24'h0, a});
      wr(8'h04, {27'h0, f});
      run(16'h0007, 1'b0, nf);
      chk(nf, 0); // four quarters only
      rd(8'h00, {24'h0, ea}); // nibble correction
      rd(8'h04, {27'h0, ef}); // only carry changes
   endtask

   task automatic dec(input logic [15:0] ins, input logic t,
                      input logic [3:0] bk, input logic e,
                      input logic [11:0] bs, input logic [11:0] a,
                      input logic [7:0] op);
      logic [7:0] r;
      logic sk;
      logic [4:0] ef;
      int nf;
      r = op - 8'h01;
      sk = (ins[15:10] == 6'h0B);
      ef = {r[7], op == 8'h80, r == 8'h00, op[3:0] != 4'h0, op != 8'h00};
      dmem_model_inst.mem[a] = op;
      base <= bs;
      wr(8'h08, {28'h0, bk});
      wr(8'h0C, {31'h0, e});
      wr(8'h00, 32'h55);
      wr(8'h04, 32'h15);
      run(ins, t, nf);
      chk(nf, (sk && r == 8'h00) ? (t ? 8 : 4) : 0); // discard
      chk(dmem_model_inst.mem[a], ins[9] ? r : op); // file target
      rd(8'h00, ins[9] ? 32'h55 : {24'h0, r}); // acc target
      rd(8'h04, sk ? 32'h15 : {27'h0, ef}); // flags
      chk(acc_o, ins[9] ? 8'h55 : r); // one cycle result
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (k = 0; k < 6; k++) begin
         if (k != 4) rd(8'(4 * k), 32'h0);
      end
      rd(8'h10, 32'h1); // idle in decode
      adj(8'hA5, 5'h00, 8'h05, 5'h01);
      adj(8'hCE, 5'h00, 8'h34, 5'h01);
      adj(8'h9A, 5'h00, 8'h00, 5'h01);
      adj(8'h12, 5'h01, 8'h72, 5'h01);
      dec(16'h0410, 0, 4'h0, 0, 12'h0, 12'h010, 8'h01);
      dec(16'h0780, 0, 4'h3, 0, 12'h0, 12'h380, 8'h80);
      dec(16'h0660, 0, 4'h0, 0, 12'h0, 12'hF60, 8'h00);
      dec(16'h0620, 0, 4'h0, 1, 12'h200, 12'h220, 8'h37);
      dec(16'h0660, 0, 4'h0, 1, 12'h200, 12'hF60, 8'hFF);
      dec(16'h2E10, 1, 4'h0, 0, 12'h0, 12'h010, 8'h01);
      dec(16'h2F11, 0, 4'h5, 0, 12'h0, 12'h511, 8'h01);
      dec(16'h2CFF, 1, 4'h0, 0, 12'h0, 12'hFFF, 8'h05);
      complete_run();
   end
endmodule
